// ==== pwg_regs.vh ====
/*
 Register map, field positions, reset values and bus constants for the
 PWM generator control and status block. Assumes inclusion by bare name.
*/
`ifndef PWG_REGS_VH
`define PWG_REGS_VH

`define PWG_ADDR_W 8
`define PWG_OFF_CTRL 8'h00
`define PWG_OFF_IRQ_STAT 8'h04
`define PWG_OFF_IRQ_MASK 8'h08
`define PWG_OFF_EFFECT 8'h0c

`define PWG_CTRL_RESET 16'h0000
`define PWG_CTRL_WMASK 16'h1ff7

`define PWG_BIT_FAULT_PENDING_FLAG 15
`define PWG_BIT_CURRENT_LIMIT_PENDING_FLAG 14
`define PWG_BIT_TRIGGER_PENDING_FLAG 13
`define PWG_BIT_FAULT_IRQ_ENABLE 12
`define PWG_BIT_CURRENT_LIMIT_IRQ_ENABLE 11
`define PWG_BIT_TRIGGER_IRQ_ENABLE 10
`define PWG_BIT_ITB 9
`define PWG_BIT_MASTER_DUTY_SELECT 8
`define PWG_DTC_HI 7
`define PWG_DTC_LO 6
`define PWG_BIT_DEAD_TIME_POLARITY 5
`define PWG_BIT_MASTER_TIME_BASE_SELECT 3
`define PWG_BIT_CAM 2
`define PWG_BIT_EXTERNAL_PERIOD_RESET_ENABLE 1
`define PWG_BIT_IUE 0

`define PWG_DTC_POL_MODE 2'h3
`define PWG_IRQ_W 3

`endif

// ==== pwg_flag.v ====
/*
 One hardware-set pending flag with enable gating and a one-to-clear
 companion sticky bit. Assumes a single pclk domain.
*/
`timescale 1ns/100ps
module pwg_flag (
	input wire pclk,
	input wire presetn,
	input wire ce,
	input wire event_in,
	input wire enable,
	input wire sticky_clr,
	output reg pending_r,
	output reg sticky_r
);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending_r <= 1'b0;
			sticky_r <= 1'b0;
		end else if (ce) begin
			// Disabled enable holds the flag clear; set wins over clear otherwise
			if (!enable)
				pending_r <= 1'b0;
			else if (event_in)
				pending_r <= 1'b1;
			if (enable && event_in)
				sticky_r <= 1'b1;
			else if (sticky_clr)
				sticky_r <= 1'b0;
		end
	end
endmodule // pwg_flag

// ==== pwg_ctrl.v ====
/*
 PWM generator channel control and status register behind an APB slave,
 with sticky interrupt status, mask and one level interrupt output.
 Assumes event inputs are synchronous one-cycle pulses on pclk.
*/
// Behaviour
// R1: Current-limit flag bit 14 shows pending interrupt
// R2: Current-limit enable written zero clears flag
// R3: Trigger flag bit 13 shows pending interrupt
// R4: Fault enable bit 12 gates, clears fault flag
// R5: Trigger enable written zero clears trigger flag
// R6: Software keeps timing fields while module enabled
// R7: Dead-time polarity counts only when control is 11
// R8: Period reset needs independent base, limit mode 0
`timescale 1ns/100ps
`include "pwg_regs.vh"
module pwg_ctrl (
	input wire pclk,
	input wire presetn,
	input wire pclk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`PWG_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire fault_event,
	input wire current_limit_event,
	input wire trigger_event,
	input wire current_limit_mode,
	output reg irq,
	output reg [15:0] config_out,
	output reg dead_time_polarity_eff,
	output reg ext_period_reset_eff
);
	reg [15:0] ctrl_r;
	reg [`PWG_IRQ_W-1:0] mask_r;
	wire [`PWG_IRQ_W-1:0] pend;
	wire [`PWG_IRQ_W-1:0] sticky;
	wire [`PWG_IRQ_W-1:0] ev;
	wire [`PWG_IRQ_W-1:0] en;
	wire setup;
	wire wr;
	wire hit_ctrl;
	wire hit_stat;
	wire hit_mask;
	wire hit_eff;
	wire hit_any;
	wire [`PWG_IRQ_W-1:0] stat_clr;
	wire [15:0] ctrl_view;
	wire [15:0] wdata16;

	// Zero-wait slave: answers in the access cycle following setup
	assign setup = psel && !penable;
	assign wr = psel && penable && pready && pwrite;
	assign hit_ctrl = (paddr == `PWG_OFF_CTRL);
	assign hit_stat = (paddr == `PWG_OFF_IRQ_STAT);
	assign hit_mask = (paddr == `PWG_OFF_IRQ_MASK);
	assign hit_eff = (paddr == `PWG_OFF_EFFECT);
	assign hit_any = hit_ctrl | hit_stat | hit_mask | hit_eff;
	assign wdata16 = {pstrb[1] ? pwdata[15:8] : ctrl_r[15:8],
		pstrb[0] ? pwdata[7:0] : ctrl_r[7:0]};

	// Flag order: 0 trigger, 1 current limit, 2 fault
	assign ev = {fault_event, current_limit_event, trigger_event};
	assign en = {ctrl_r[`PWG_BIT_FAULT_IRQ_ENABLE], ctrl_r[`PWG_BIT_CURRENT_LIMIT_IRQ_ENABLE], ctrl_r[`PWG_BIT_TRIGGER_IRQ_ENABLE]};
	assign stat_clr = (wr && hit_stat && pstrb[0]) ? pwdata[`PWG_IRQ_W-1:0] : 3'h0;

	// Enables come straight from the register, so a zero write clears next edge
	pwg_flag u_trg ( // R3 R5
		.pclk(pclk), .presetn(presetn), .ce(pclk_en), .event_in(ev[0]),
		.enable(en[0]), .sticky_clr(stat_clr[0]), .pending_r(pend[0]),
		.sticky_r(sticky[0]));
	pwg_flag u_cl ( // R1 R2
		.pclk(pclk), .presetn(presetn), .ce(pclk_en), .event_in(ev[1]),
		.enable(en[1]), .sticky_clr(stat_clr[1]), .pending_r(pend[1]),
		.sticky_r(sticky[1]));
	pwg_flag u_flt ( // R4
		.pclk(pclk), .presetn(presetn), .ce(pclk_en), .event_in(ev[2]),
		.enable(en[2]), .sticky_clr(stat_clr[2]), .pending_r(pend[2]),
		.sticky_r(sticky[2]));

	assign ctrl_view = {pend[2], pend[1], pend[0], ctrl_r[12:0]}; // R1 R3

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `PWG_CTRL_RESET;
			mask_r <= 3'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (pclk_en) begin
			pready <= setup;
			pslverr <= setup && !hit_any;
			if (wr && hit_ctrl)
				ctrl_r <= wdata16 & `PWG_CTRL_WMASK;
			if (wr && hit_mask && pstrb[0])
				mask_r <= pwdata[`PWG_IRQ_W-1:0];
			if (setup && !pwrite) begin
				if (hit_ctrl)
					prdata <= {16'h0000, ctrl_view};
				else if (hit_stat)
					prdata <= {29'h0, sticky};
				else if (hit_mask)
					prdata <= {29'h0, mask_r};
				else if (hit_eff)
					prdata <= {30'h0, ext_period_reset_eff, dead_time_polarity_eff};
				else
					prdata <= 32'h00000000;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
			config_out <= 16'h0000;
			dead_time_polarity_eff <= 1'b0;
			ext_period_reset_eff <= 1'b0;
		end else if (pclk_en) begin
			irq <= |(sticky & mask_r);
			config_out <= ctrl_view;
			// Polarity is ignored unless dead-time control selects mode 11
			dead_time_polarity_eff <= ctrl_r[`PWG_BIT_DEAD_TIME_POLARITY] &&
				(ctrl_r[`PWG_DTC_HI:`PWG_DTC_LO] == `PWG_DTC_POL_MODE); // R7
			// Period reset only qualifies with independent base and limit mode 0
			ext_period_reset_eff <= ctrl_r[`PWG_BIT_EXTERNAL_PERIOD_RESET_ENABLE] &&
				ctrl_r[`PWG_BIT_ITB] && !current_limit_mode; // R8
		end
	end
endmodule // pwg_ctrl

// ==== pwg_ctrl_sva.sv ====
/* Port checker for pwg_ctrl.
 Assumes one pclk domain; attached by the bind below. */
`timescale 1ns/100ps
module pwg_ctrl_sva (
	input logic pclk,
	input logic presetn,
	input logic pclk_en,
	input logic psel,
	input logic penable,
	input logic fault_event,
	input logic current_limit_event,
	input logic trigger_event,
	input logic current_limit_mode,
	input logic [15:0] config_out,
	input logic pready,
	input logic dead_time_polarity_eff,
	input logic ext_period_reset_eff
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// The view lags the flag by one edge, so a flag shows two edges after its event
	cl_set_a: assert property (pclk_en && current_limit_event ##1 pclk_en && config_out[11]
		|=> config_out[14]) else $error("limit flag not set");
	cl_clr_a: assert property (pclk_en ##1 pclk_en && !config_out[11] |=> !config_out[14])
		else $error("limit flag not cleared");
	trg_set_a: assert property (pclk_en && trigger_event ##1 pclk_en && config_out[10]
		|=> config_out[13]) else $error("trigger flag not set");
	trg_clr_a: assert property (pclk_en ##1 pclk_en && !config_out[10] |=> !config_out[13])
		else $error("trigger flag not cleared");
	flt_set_a: assert property (pclk_en && fault_event ##1 pclk_en && config_out[12]
		|=> config_out[15]) else $error("fault flag not set");
	flt_clr_a: assert property (pclk_en ##1 pclk_en && !config_out[12] |=> !config_out[15])
		else $error("fault flag not cleared");
	pol_eff_a: assert property (dead_time_polarity_eff ==
		(config_out[5] && config_out[7:6] == 2'h3)) else $error("polarity view wrong");
	xpr_eff_a: assert property (pclk_en ##1 $stable(current_limit_mode) |->
		ext_period_reset_eff == (config_out[1] && config_out[9] && !current_limit_mode))
		else $error("reset view wrong");
	apb_ready_a: assert property (pclk_en && psel && !penable |=> pready)
		else $error("no ready after setup");
endmodule // pwg_ctrl_sva
bind pwg_ctrl pwg_ctrl_sva u_pwg_ctrl_sva (
	.pclk(pclk),
	.presetn(presetn),
	.pclk_en(pclk_en),
	.psel(psel),
	.penable(penable),
	.fault_event(fault_event),
	.current_limit_event(current_limit_event),
	.trigger_event(trigger_event),
	.current_limit_mode(current_limit_mode),
	.config_out(config_out),
	.pready(pready),
	.dead_time_polarity_eff(dead_time_polarity_eff),
	.ext_period_reset_eff(ext_period_reset_eff)
);

// ==== pwg_ctrl_tb_top.sv ====
/* APB sequence bench for pwg_ctrl.
 Assumes the map in pwg_regs.vh and single-cycle answers. */
`timescale 1ns/100ps
module pwg_ctrl_tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, current_limit_mode = 0;
	logic fault_event = 0, current_limit_event = 0, trigger_event = 0;
	logic pclk_en = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, irq, dead_time_polarity_eff, ext_period_reset_eff;
	logic [15:0] config_out;
	int fails = 0, cmp_count = 0;
	always #5 pclk = ~pclk;
	pwg_ctrl u_pwg_ctrl (
		.pclk(pclk),
		.presetn(presetn),
		.pclk_en(pclk_en),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(4'hf),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.fault_event(fault_event),
		.current_limit_event(current_limit_event),
		.trigger_event(trigger_event),
		.current_limit_mode(current_limit_mode),
		.irq(irq),
		.config_out(config_out),
		.dead_time_polarity_eff(dead_time_polarity_eff),
		.ext_period_reset_eff(ext_period_reset_eff)
	);
	task chk(input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %0t seen %h want %h", $time, s, e);
		end
	endtask
	task complete_run;
		$display("fails %0d cmp_count %0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, e, input logic er = 0);
		int n;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		// Ready and read data are taken at the edge itself, before the design updates them
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fails++;
			complete_run;
		end
		if (!w) chk(prdata, e);
		chk(pslverr, er);
		psel <= 0;
		penable <= 0;
	endtask
	task ev(input logic [2:0] v);
		@(posedge pclk);
		{fault_event, current_limit_event, trigger_event} <= v;
		@(posedge pclk);
		{fault_event, current_limit_event, trigger_event} <= 3'h0;
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		apb(0, 8'h00, 0, 32'h0000);
		chk(config_out, 32'h0);
		apb(1, 8'h00, 32'hffff, 0);
		apb(0, 8'h00, 0, 32'h1ff7);
		apb(0, 8'h0c, 0, 32'h3);
		chk(dead_time_polarity_eff, 32'h1);
		chk(ext_period_reset_eff, 32'h1);
		current_limit_mode <= 1;
		apb(0, 8'h0c, 0, 32'h1);
		chk(ext_period_reset_eff, 32'h0);
		apb(1, 8'h00, 32'h1c60, 0);
		apb(0, 8'h0c, 0, 32'h0);
		chk(dead_time_polarity_eff, 32'h0);
		ev(3'h7);
		apb(0, 8'h00, 0, 32'hfc60);
		chk(config_out, 32'hfc60);
		apb(1, 8'h08, 32'h7, 0);
		apb(0, 8'h04, 0, 32'h7);
		chk(irq, 1);
		apb(1, 8'h00, 32'h0, 0);
		apb(0, 8'h00, 0, 32'h0);
		apb(1, 8'h04, 32'h7, 0);
		ev(3'h7);
		apb(0, 8'h04, 0, 32'h0);
		chk(irq, 0);
		apb(1, 8'h08, 32'h0, 0);
		apb(1, 8'h00, 32'h1c00, 0);
		ev(3'h2);
		apb(0, 8'h04, 0, 32'h2);
		chk(irq, 0);
		// A trigger pulse while the clock enable is low must leave every flag alone
		pclk_en <= 1'b0;
		ev(3'h1);
		pclk_en <= 1'b1;
		apb(0, 8'h00, 0, 32'h5c00);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8'h00, 0, 32'h0);
		chk(config_out, 32'h0);
		chk(irq, 32'h0);
		apb(0, 8'h10, 0, 32'h0, 1);
		complete_run;
	end
endmodule // pwg_ctrl_tb_top
